// ==== hdl/ppg_programmer.sv ====
// Functional notes
// R1: Blank part reads zero; only ones written
// R2: Target has 256 eight-bit words
// R3: Device decodes address as in read
// R4: Complement address when supplies go negative
// R5: Complement held at least 25 us
// R6: True address 10 us before pulse
// R7: Ascending sweep 0..255, 32 times minimum
// R8: Output pins carry write data
// R9: Low data level programs a one
// R10: Whole word written in one pulse
// R11: Supplies and program driven as pulses
// R12: Device is static, needs no clock
// R13: Per-word step order, then advance
`timescale 1ns/10ps
`default_nettype none
module ppg_programmer
  import ppg_pkg::*;
#(
  parameter int PULSE_CYC = T_PULSE_US * 1000 / CLK_PERIOD_NS, // Pulse, rounded down
  parameter int OFF_CYC = T_OFF_US * 1000 / CLK_PERIOD_NS // Rest between words
) (
  input wire logic core_clk, // Clock
  input wire logic rst_b, // Synchronous reset, low
  input wire logic start, // Begin programming, pulse
  input wire logic [5:0] sweepCount, // Sweeps to run, below 32 uses 32
  output logic wordReq, // Data wanted for wordAddr
  output logic [ADDR_W-1:0] wordAddr, // Word needing data
  input wire logic [DATA_W-1:0] wordData, // Image byte for wordAddr
  output logic busy, // Sequence running
  output logic doneP, // One-cycle pulse at finish
  output logic [ADDR_W-1:0] promAddr, // Address pins, true high
  output logic [DATA_W-1:0] promDataOut, // Data pins drive value
  output logic [DATA_W-1:0] promDataOe, // Data pins driven
  output logic gateSupplyOn, // Pulsed_gate_supply negative
  output logic drainSupplyOn, // Pulsed drain supply negative
  output logic progPulseOn, // Program pulse negative
  output logic progMode // Programming connection, bias applied
);
  ppg_timer_if tif (); // Interval timer link
  ppg_state_e state_q; // Sequencer state
  logic [ADDR_W-1:0] addr_q; // Current word
  logic [5:0] sweep_q; // Sweeps finished
  logic [5:0] target_q; // Sweeps wanted
  logic done_q; // Finish pulse
  logic lastWord; // Final word of final sweep
  logic stepDone; // Rest over, go to next word
  logic finish; // Rest over, whole image written
  // Interval timer, one interval per phase
  ppg_timer u_tmr (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .tif(tif)
  );
  // Sweep count compared one ahead, so the last sweep ends cleanly
  assign lastWord = (addr_q == ADDR_LAST) && (sweep_q + 6'h1 >= target_q);
  assign stepDone = (state_q == PPG_OFF) && tif.done && !lastWord;
  assign finish = (state_q == PPG_OFF) && tif.done && lastWord;
  // Entering each timed state loads its interval
  always_comb begin
    tif.load = 1'b0;
    tif.count = 32'h0;
    case (state_q)
      // Complement phase follows an accepted start
      PPG_IDLE: begin
        tif.load = start;
        tif.count = CNT_W'(CYC_COMP); // R5
      end
      // True address waits out the rest of the supply setup
      PPG_COMP: begin
        tif.load = tif.done;
        tif.count = CNT_W'(CYC_TRUE); // R6
      end
      // Program pulse width
      PPG_TRUE: begin
        tif.load = tif.done;
        tif.count = CNT_W'(PULSE_CYC);
      end
      // Data, address and supplies held after the pulse
      PPG_PULSE: begin
        tif.load = tif.done;
        tif.count = CNT_W'(CYC_HOLD);
      end
      // Supplies off; a long rest keeps the duty cycle low
      PPG_HOLD: begin
        tif.load = tif.done;
        tif.count = CNT_W'(OFF_CYC);
      end
      // Next word, unless the image is complete
      PPG_OFF: begin
        tif.load = stepDone;
        tif.count = CNT_W'(CYC_COMP);
      end
      // Unreachable codes load nothing
      default: begin
        tif.load = 1'b0;
        tif.count = 32'h0;
      end
    endcase
  end
  // Sequencer: comp, true, pulse, hold, rest, advance
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_q <= PPG_IDLE;
    end else begin
      case (state_q)
        PPG_IDLE: begin
          // A start while running never reaches here, so it is ignored
          if (start) state_q <= PPG_COMP; // R13
        end
        PPG_COMP: begin
          // Complement held long enough; switch to true address
          if (tif.done) state_q <= PPG_TRUE; // R13
        end
        PPG_TRUE: begin
          // Supplies settled; apply the program pulse
          if (tif.done) state_q <= PPG_PULSE; // R13
        end
        PPG_PULSE: begin
          // Pulse over; keep everything for the hold time
          if (tif.done) state_q <= PPG_HOLD; // R13
        end
        PPG_HOLD: begin
          // Release supplies and data, then rest
          if (tif.done) state_q <= PPG_OFF; // R13
        end
        PPG_OFF: begin
          // Rest over: next word or back to idle
          if (stepDone) state_q <= PPG_COMP; // R13
          else if (finish) state_q <= PPG_IDLE;
        end
        default: state_q <= PPG_IDLE;
      endcase
    end
  end
  // Address and sweep counting, ascending with wrap
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      addr_q <= ADDR_FIRST;
      sweep_q <= 6'h0;
      target_q <= 6'h0;
    end else if (state_q == PPG_IDLE && start) begin
      addr_q <= ADDR_FIRST; // R7
      sweep_q <= 6'h0;
      // Fewer than the least sweep count is never allowed
      target_q <= (sweepCount < 6'(SWEEP_MIN)) ? 6'(SWEEP_MIN) : sweepCount; // R7
    end else if (state_q == PPG_OFF && tif.done) begin
      // Wraps to the first word after the last; the sweep counter saturates
      addr_q <= addr_q + 8'h1; // R7
      if (addr_q == ADDR_LAST && sweep_q != SWEEP_W_MAX) begin
        sweep_q <= sweep_q + 6'h1; // R7
      end
    end
  end
  // Finish pulse, one cycle as the sequencer returns to idle
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      done_q <= 1'b0;
    end else begin
      done_q <= finish;
    end
  end
  // Address pins: complement first, then true value
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      promAddr <= 8'h00;
    end else if (state_q == PPG_IDLE && start) begin
      // First word, complemented as the supplies go negative
      promAddr <= ~ADDR_FIRST; // R4
    end else if (state_q == PPG_COMP && tif.done) begin
      // Switch to true only after the complement hold
      promAddr <= addr_q; // R6 R3
    end else if (stepDone) begin
      // Next word, complemented again with the supplies
      promAddr <= ~(addr_q + 8'h1); // R4
    end
  end
  // Data pins: a one in the image drives the pin low
  // Taken on the last complement cycle and held past the pulse
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      promDataOut <= 8'h00;
      promDataOe <= 8'h00;
    end else if (state_q == PPG_COMP && tif.done) begin
      promDataOut <= ~wordData; // R9 R8 R10
      promDataOe <= 8'hff; // R8
    end else if (state_q == PPG_HOLD && tif.done) begin
      // Pins released with the supplies
      promDataOut <= 8'h00;
      promDataOe <= 8'h00;
    end
  end
  // Gate and drain supplies pulsed together per word
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      gateSupplyOn <= 1'b0;
      drainSupplyOn <= 1'b0;
    end else if ((state_q == PPG_IDLE && start) || stepDone) begin
      // Rise together with the complement address
      gateSupplyOn <= 1'b1; // R11 R4
      drainSupplyOn <= 1'b1; // R11 R4
    end else if (state_q == PPG_HOLD && tif.done) begin
      // Fall only after the hold time, never during the pulse
      gateSupplyOn <= 1'b0; // R11
      drainSupplyOn <= 1'b0; // R11
    end
  end
  // Program pulse spans exactly the pulse state
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      progPulseOn <= 1'b0;
    end else if (state_q == PPG_TRUE && tif.done) begin
      progPulseOn <= 1'b1; // R11
    end else if (state_q == PPG_PULSE && tif.done) begin
      progPulseOn <= 1'b0; // R11
    end
  end
  // Programming connection from accepted start to the last word's rest
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      progMode <= 1'b0;
    end else if (state_q == PPG_IDLE && start) begin
      progMode <= 1'b1;
    end else if (finish) begin
      progMode <= 1'b0;
    end
  end
  // Handshake and status outputs: wordReq and busy decoded from state, wordAddr and doneP from registers
  assign wordReq = (state_q == PPG_COMP);
  assign wordAddr = addr_q;
  assign busy = (state_q != PPG_IDLE);
  assign doneP = done_q;
endmodule // ppg_programmer
`default_nettype wire

// ==== hdl/ppg_pkg.sv ====
package ppg_pkg;
  localparam int CLK_PERIOD_NS = 10; // Core clock period
  localparam int WORD_COUNT = 256; // Words in the memory
  localparam int ADDR_W = 8; // Address width
  localparam int DATA_W = 8; // Word width
  localparam logic [ADDR_W-1:0] ADDR_FIRST = 8'h00; // Sweep start
  localparam logic [ADDR_W-1:0] ADDR_LAST = 8'hff; // Sweep end
  localparam int SWEEP_MIN = 32; // Least number of full sweeps
  localparam logic [5:0] SWEEP_W_MAX = 6'h3f; // Sweep count field limit
  // Times in microseconds
  localparam int T_SUPPLY_SETUP_US = 100; // Supplies negative before pulse
  localparam int T_COMP_HOLD_US = 25; // Complement address hold
  localparam int T_TRUE_SETUP_US = 10; // True address before program pulse
  localparam int T_PULSE_US = 3000; // Program pulse width (3 ms)
  localparam int T_DATA_HOLD_US = 10; // Data and address hold after pulse
  localparam int T_SUPPLY_HOLD_US = 10; // Supplies held after pulse
  localparam int T_OFF_US = 16000; // Supplies off, keeps duty under 20 %
  // Cycle counts, least times rounded up
  localparam int CYC_COMP = (T_COMP_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_TRUE =
    ((T_SUPPLY_SETUP_US - T_COMP_HOLD_US) * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYC_HOLD = (T_DATA_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 32; // Timer width
  typedef enum logic [5:0] {
    PPG_IDLE = 6'h01,
    PPG_COMP = 6'h02,
    PPG_TRUE = 6'h04,
    PPG_PULSE = 6'h08,
    PPG_HOLD = 6'h10,
    PPG_OFF = 6'h20
  } ppg_state_e;
endpackage

// ==== hdl/ppg_timer_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface ppg_timer_if;
  import ppg_pkg::*;
  logic load; // Start a new interval
  logic [CNT_W-1:0] count; // Interval length in cycles
  logic done; // Interval elapsed
  modport ctrl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

// ==== hdl/ppg_timer.sv ====
`timescale 1ns/10ps
`default_nettype none
module ppg_timer
  import ppg_pkg::*;
(
  input wire logic core_clk, // Clock
  input wire logic rst_b, // Synchronous reset, low
  ppg_timer_if.tmr tif // Load and done
);
  logic [CNT_W-1:0] remain_q; // Cycles left
  // Count down to zero; done while remain is one
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      remain_q <= '0;
    end else if (tif.load) begin
      remain_q <= tif.count;
    end else if (remain_q != '0) begin
      remain_q <= remain_q - 32'h1;
    end
  end
  // Done must not look at load: the sequencer builds load from done
  assign tif.done = (remain_q == 32'h1);
endmodule // ppg_timer
`default_nettype wire

// ==== dv/ppg_programmer_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module ppg_programmer_sva
  import ppg_pkg::*;
#(
  parameter int PULSE_CYC = 20, // Pulse
  parameter int OFF_CYC = 100 // Rest
) (
  input wire logic core_clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic start, // Start
  input wire logic busy, // Running
  input wire logic [ADDR_W-1:0] wordAddr, // Word
  input wire logic [DATA_W-1:0] wordData, // Image
  input wire logic [ADDR_W-1:0] promAddr, // Pins
  input wire logic [DATA_W-1:0] promDataOut, // Data
  input wire logic [DATA_W-1:0] promDataOe, // Enables
  input wire logic gateSupplyOn, // Gate
  input wire logic drainSupplyOn, // Drain
  input wire logic progPulseOn, // Pulse
  input wire logic progMode // Mode
);
  localparam int TRUE_MIN = T_TRUE_SETUP_US * 1000 / CLK_PERIOD_NS; // Least true setup
  logic [CNT_W-1:0] stillCnt_q; // Age of address pins
  logic [CNT_W-1:0] pulseCnt_q; // Cycles with the pulse applied
  logic [CNT_W-1:0] offCnt_q; // Cycles of rest between words
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // Restarts whenever the pins move, so one counter serves both setups
  always_ff @(posedge core_clk) begin
    if (!rst_b || $changed(promAddr)) stillCnt_q <= '0;
    else stillCnt_q <= stillCnt_q + 1;
  end
  // Pulse length counted while the pulse stands
  always_ff @(posedge core_clk) begin
    if (!rst_b || !progPulseOn) pulseCnt_q <= '0;
    else pulseCnt_q <= pulseCnt_q + 1;
  end
  // Rest counted while running with supplies released
  always_ff @(posedge core_clk) begin
    if (!rst_b || gateSupplyOn || !busy) offCnt_q <= '0;
    else offCnt_q <= offCnt_q + 1;
  end
  sequence hold_s; // Data and gate supply kept after pulse
    (gateSupplyOn && promDataOe == 8'hff) [*8];
  endsequence
  sequence off_s; // Supplies then released
    ##[0:999] !gateSupplyOn && !drainSupplyOn;
  endsequence
  start_resp_a: assert property (start && !busy |=> gateSupplyOn && progMode
    && promAddr == ~wordAddr) else $error("bad start response");
  comp_addr_a: assert property ($rose(gateSupplyOn) |-> promAddr == ~wordAddr
    && drainSupplyOn) else $error("address not complemented");
  comp_hold_a: assert property (gateSupplyOn && $stable(gateSupplyOn)
    && $changed(promAddr) |-> stillCnt_q >= CYC_COMP - 1) else $error("complement short");
  true_setup_a: assert property ($rose(progPulseOn) |-> promAddr == wordAddr
    && stillCnt_q >= TRUE_MIN) else $error("true address late");
  pulse_data_a: assert property (progPulseOn |-> promDataOe == 8'hff
    && promDataOut == ~wordData) else $error("bad data pins");
  pulse_inside_a: assert property (progPulseOn |-> gateSupplyOn && drainSupplyOn
    && progMode) else $error("pulse outside supplies");
  supply_release_a: assert property ($fell(progPulseOn) |-> hold_s ##1 off_s)
    else $error("bad supply release");
  addr_step_a: assert property (busy && $past(busy) && $changed(wordAddr)
    |-> wordAddr == 8'($past(wordAddr) + 8'h01)) else $error("address skipped");
  pulse_width_a: assert property ($fell(progPulseOn)
    |-> pulseCnt_q == PULSE_CYC) else $error("pulse width wrong");
  rest_gap_a: assert property ($rose(gateSupplyOn) && $past(busy)
    |-> offCnt_q == OFF_CYC) else $error("rest between words wrong");
endmodule // ppg_programmer_sva
`default_nettype wire

// ==== dv/ppg_prom_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module ppg_prom_model
  import ppg_pkg::*;
(
  input wire logic [ADDR_W-1:0] promAddr, // Address
  input wire logic [DATA_W-1:0] promDataOut, // Data
  input wire logic [DATA_W-1:0] promDataOe, // Enables
  input wire logic gateSupplyOn, // Gate
  input wire logic drainSupplyOn, // Drain
  input wire logic progPulseOn, // Pulse
  input wire logic progMode // Mode
);
  logic [DATA_W-1:0] mem [WORD_COUNT]; // Cells, 256 by 8
  logic [DATA_W-1:0] pinLvl; // Pin level
  // Undriven pins sit high, which programs nothing
  assign pinLvl = (promDataOut & promDataOe) | ~promDataOe;
  // Blank part
  initial begin
    foreach (mem[i]) mem[i] = '0;
  end
  // No clock: the pulse edge commits all bits, ones only
  always @(negedge progPulseOn) begin
    if (progMode && gateSupplyOn && drainSupplyOn) mem[promAddr] |= ~pinLvl;
  end
endmodule // ppg_prom_model
`default_nettype wire

// ==== dv/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ppg_pkg::*;
  localparam int PULSE_CYC = 20; // Short pulse
  localparam int OFF_CYC = 100; // Short rest
  logic core_clk = 1'b0; // Clock
  logic rst_b = 1'b0; // Reset
  logic start = 1'b0; // Start
  logic [5:0] sweepCount = 6'h00; // Below minimum
  logic [7:0] wordData = 8'h00; // Image
  logic wordReq, busy, doneP, gateSupplyOn, drainSupplyOn, progPulseOn, progMode; // Outputs
  logic [7:0] wordAddr, promAddr, promDataOut, promDataOe; // Buses
  int miscompares = 0; // Mismatches
  int checked = 0; // Compares
  int cyc = 0; // Timeout count
  always #5 core_clk = ~core_clk;
  ppg_programmer #(.PULSE_CYC(PULSE_CYC), .OFF_CYC(OFF_CYC)) i_ppg_programmer (
    .core_clk(core_clk), .rst_b(rst_b), .start(start), .sweepCount(sweepCount),
    .wordReq(wordReq), .wordAddr(wordAddr), .wordData(wordData), .busy(busy), .doneP(doneP),
    .promAddr(promAddr), .promDataOut(promDataOut), .promDataOe(promDataOe),
    .gateSupplyOn(gateSupplyOn), .drainSupplyOn(drainSupplyOn), .progPulseOn(progPulseOn),
    .progMode(progMode));
  ppg_prom_model i_ppg_prom_model (.promAddr(promAddr), .promDataOut(promDataOut),
    .promDataOe(promDataOe), .gateSupplyOn(gateSupplyOn), .drainSupplyOn(drainSupplyOn),
    .progPulseOn(progPulseOn), .progMode(progMode));
  function automatic logic [7:0] img(input logic [7:0] a);
    return a ^ 8'h3c;
  endfunction
  // Image byte follows the word asked for
  always @(posedge core_clk) #1 wordData = img(wordAddr);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic kick();
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask
  // Quiet outputs after reset
  task automatic t_idle();
    chk({2'b00, busy, gateSupplyOn, drainSupplyOn, progPulseOn, progMode, doneP}, 8'h00);
    chk(promDataOe, 8'h00);
  endtask
  // Six words written; a second start while running is ignored
  task automatic t_program();
    int n;
    n = 0;
    kick();
    chk(promAddr, 8'hff);
    chk({4'h0, wordReq, gateSupplyOn, drainSupplyOn, progMode}, 8'h0f);
    tick(1);
    kick();
    chk(wordAddr, 8'h00);
    while (wordAddr !== 8'h06 && n < 80000) begin
      tick(1);
      n++;
    end
    chk(wordAddr, 8'h06);
    for (int a = 0; a < 8; a++) chk(i_ppg_prom_model.mem[a], a < 6 ? img(8'(a)) : 8'h00);
  endtask
  // Reset mid-word, then restart from the first word
  task automatic t_midreset();
    tick(200);
    rst_b = 1'b0;
    tick(2);
    t_idle();
    rst_b = 1'b1;
    kick();
    chk(promAddr, 8'hff);
    chk(wordAddr, 8'h00);
  endtask
  initial begin
    tick(4);
    rst_b = 1'b1;
    t_idle();
    t_program();
    t_midreset();
    end_sim();
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 90000) begin
      miscompares++;
      end_sim();
    end
  end
endmodule // testbench
bind ppg_programmer ppg_programmer_sva #(.PULSE_CYC(PULSE_CYC), .OFF_CYC(OFF_CYC))
  i_ppg_programmer_sva (.core_clk(core_clk), .rst_b(rst_b), .start(start), .busy(busy),
  .wordAddr(wordAddr), .wordData(wordData), .promAddr(promAddr), .promDataOut(promDataOut),
  .promDataOe(promDataOe), .gateSupplyOn(gateSupplyOn), .drainSupplyOn(drainSupplyOn),
  .progPulseOn(progPulseOn), .progMode(progMode));
`default_nettype wire
